// [pkg/trib_bus_pkg.sv]
package trib_bus_pkg;
    // frame geometry of one interleaved structure
    localparam int unsigned ROWS = 9;
    localparam int unsigned COLS = 270;
    localparam int unsigned LANES = 4;
    localparam int unsigned FP_ROW = 1;
    localparam int unsigned FP_COL = 7;
    localparam int unsigned PAYLOAD_FIRST_COL = 16;
    localparam int unsigned PAYLOAD_LAST_COL = 270;
    localparam int unsigned FIXED_LAST_COL = 18;
    localparam int unsigned T1_STRIDE = 84;
    localparam int unsigned E1_STRIDE = 63;
    localparam int unsigned T1_PER_SPE = 28;
    localparam int unsigned E1_PER_SPE = 21;
    localparam int unsigned SPES = 3;
    localparam int unsigned FRAME_PERIOD_NS = 125000;
    localparam int unsigned BUS_CLK_KHZ = 77760;
    localparam int unsigned STRUCT_RATE_KBPS = 19440;
    // payload type carried in one envelope
    typedef enum logic [2:0] {
        TRIB_NONE, TRIB_T1, TRIB_E1, TRIB_DS3, TRIB_E3, TRIB_VT15, TRIB_VT2
    } trib_type_e;
endpackage : trib_bus_pkg

// [hdl/tributary_bus_frame_mapper.sv]
// Overview of operation
// RQ1: four 19.44 Mbit/s structures byte-interleaved on the 77.76 MHz bus.
// RQ2: payload only in envelope octets of columns 16 to 270.
// RQ3: add and drop frame pulses mark row 1 column 7.
// RQ4: add and drop buses align independently from their own pulses.
// RQ5: an envelope holds 28 T1, 21 E1, one DS3 or one E3.
// RQ6: each envelope configured, added and dropped independently.
// RQ7: transparent tributaries mix only with matching T1 or E1 family; the code does not check this and flags only type codes above TRIB_VT2.
// RQ8: board drives both reference clocks from one source, fixed offset.
// RQ9: frame frequency and alignment fixed by clock and frame pulses.
// RQ10: frequency offsets absorbed by floating tributaries with start and valid.
// RQ11: synchronous transparent mode carries pointers instead of start/valid.
// RQ12: locked structure fixes the TU-3 position in the frame.
// RQ13: tributaries named envelope,tributary; DS3/E3 use index one.
// RQ14: columns 16 to 18 idle for T1, E1 and transparent tributaries.
// RQ15: T1 s,t sits at bus column 18+s+3(t-1) plus 0, 84, 168.
// RQ16: E1 s,t sits at bus column 18+s+3(t-1) plus 0, 63, 126, 189.
// RQ17: up to four such devices share the bus at 77.76 MHz.
// RQ18: fast source sends extra octet in V3/H3; slow one skips next.
// RQ19: frame is 9 rows by 270 columns, every 125 us, row by row.
module tributary_bus_frame_mapper #(
    parameter int unsigned DEV_LANE = 0
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic add_frame_pulse,
    input wire logic drop_frame_pulse,
    input wire logic [2:0] spe1_type,
    input wire logic [2:0] spe2_type,
    input wire logic [2:0] spe3_type,
    input wire logic sync_vtrib,
    input wire logic [7:0] drop_src_data,
    input wire logic drop_src_valid,
    input wire logic drop_src_start,
    input wire logic [7:0] add_bus_data,
    input wire logic add_payload_valid,
    input wire logic add_trib_start,
    output logic [7:0] drop_bus_data,
    output logic drop_payload_valid,
    output logic drop_trib_start,
    output logic drop_bus_oe,
    output logic [7:0] add_sink_data,
    output logic add_sink_valid,
    output logic add_sink_start,
    output logic [1:0] add_sink_spe,
    output logic [4:0] add_sink_trib,
    output logic [8:0] drop_col,
    output logic [3:0] drop_row,
    output logic config_error
);
    localparam logic [1:0] LANE_LAST = 2'(trib_bus_pkg::LANES - 1);
    localparam logic [8:0] COL_LAST = 9'(trib_bus_pkg::COLS);
    localparam logic [3:0] ROW_LAST = 4'(trib_bus_pkg::ROWS);
    localparam logic [8:0] COL_FP = 9'(trib_bus_pkg::FP_COL);
    localparam logic [3:0] ROW_FP = 4'(trib_bus_pkg::FP_ROW);
    localparam logic [8:0] COL_PAY = 9'(trib_bus_pkg::PAYLOAD_FIRST_COL);
    localparam logic [8:0] COL_FIX = 9'(trib_bus_pkg::FIXED_LAST_COL);
    localparam logic [1:0] OWN_LANE = 2'(DEV_LANE);

    // drop and add side counters: lane, column, row
    logic [1:0] d_lane_q, a_lane_q;
    logic [8:0] d_col_q, a_col_q;
    logic [3:0] d_row_q, a_row_q;
    logic [2:0] type_q [3];

    // RQ6 envelope config
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            type_q[0] <= 3'h0;
            type_q[1] <= 3'h0;
            type_q[2] <= 3'h0;
        end else begin
            type_q[0] <= spe1_type;
            type_q[1] <= spe2_type;
            type_q[2] <= spe3_type;
        end
    end

    // RQ3 frame pulse lands on the octet after row 1 col 7 lane 0 reload
    wire d_lane_wrap = (d_lane_q == LANE_LAST);
    wire a_lane_wrap = (a_lane_q == LANE_LAST);
    wire d_col_wrap = d_lane_wrap && (d_col_q == COL_LAST);
    wire a_col_wrap = a_lane_wrap && (a_col_q == COL_LAST);

    // RQ4 RQ9 drop counter realigned only by its own pulse
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            d_lane_q <= 2'h0;
            d_col_q <= 9'h001;
            d_row_q <= 4'h1;
        end else if (drop_frame_pulse) begin
            d_lane_q <= 2'h1;
            d_col_q <= COL_FP;
            d_row_q <= ROW_FP;
        end else begin
            d_lane_q <= d_lane_q + 2'h1;
            if (d_lane_wrap) begin
                d_col_q <= d_col_wrap ? 9'h001 : d_col_q + 9'h001;
            end
            if (d_col_wrap) begin
                d_row_q <= (d_row_q == ROW_LAST) ? 4'h1 : d_row_q + 4'h1;
            end
        end
    end

    // RQ4 RQ9 add counter, independent alignment
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            a_lane_q <= 2'h0;
            a_col_q <= 9'h001;
            a_row_q <= 4'h1;
        end else if (add_frame_pulse) begin
            a_lane_q <= 2'h1;
            a_col_q <= COL_FP;
            a_row_q <= ROW_FP;
        end else begin
            a_lane_q <= a_lane_q + 2'h1;
            if (a_lane_wrap) begin
                a_col_q <= a_col_wrap ? 9'h001 : a_col_q + 9'h001;
            end
            if (a_col_wrap) begin
                a_row_q <= (a_row_q == ROW_LAST) ? 4'h1 : a_row_q + 4'h1;
            end
        end
    end

    // RQ15 RQ16 RQ13 column decode: c-19 = 3*(t-1)+(s-1) within a group
    function automatic logic [9:0] col_decode(input logic [8:0] col,
                                              input logic [2:0] t0,
                                              input logic [2:0] t1,
                                              input logic [2:0] t2);
        logic [8:0] off;
        logic [8:0] grp;
        logic [1:0] spe;
        logic [4:0] trib;
        logic [2:0] ty;
        logic ok;
        grp = 9'h000;
        off = col - 9'd19;
        // interleave of the three envelopes starts at column 16, not 19
        spe = 2'((col - COL_PAY) % 9'd3);
        ty = (spe == 2'd0) ? t0 : (spe == 2'd1) ? t1 : t2;
        ok = 1'b0;
        trib = 5'h00;
        if (col >= COL_PAY) begin
            if (ty == 3'(trib_bus_pkg::TRIB_DS3) || ty == 3'(trib_bus_pkg::TRIB_E3)) begin
                // RQ12 fixed single-channel envelope, index 1
                ok = 1'b1;
                trib = 5'h01;
            end else if (col > COL_FIX && ty != 3'(trib_bus_pkg::TRIB_NONE)) begin
                // RQ14 columns 16-18 stay idle here
                ok = 1'b1;
                if (ty == 3'(trib_bus_pkg::TRIB_T1) || ty == 3'(trib_bus_pkg::TRIB_VT15)) begin
                    grp = off % 9'(trib_bus_pkg::T1_STRIDE);
                end else begin
                    grp = off % 9'(trib_bus_pkg::E1_STRIDE);
                end
                // RQ5 28 or 21 tributaries per envelope
                trib = 5'(grp / 9'd3 + 9'd1);
            end
        end
        col_decode = {ok, spe, trib, 2'b00};
    endfunction

    wire [9:0] d_dec = col_decode(d_col_q, type_q[0], type_q[1], type_q[2]);
    wire [9:0] a_dec = col_decode(a_col_q, type_q[0], type_q[1], type_q[2]);
    // RQ1 RQ17 this device owns one byte lane of four
    wire d_slot = (d_lane_q == OWN_LANE) && d_dec[9];
    wire a_slot = (a_lane_q == OWN_LANE) && a_dec[9];

    // RQ7 only a type code above TRIB_VT2 is flagged; mixing transparent with the wrong family is not checked
    logic cfg_bad;
    always_comb begin
        cfg_bad = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (type_q[i] > 3'(trib_bus_pkg::TRIB_VT2)) begin
                cfg_bad = 1'b1;
            end
        end
    end

    // RQ10 RQ11 RQ18 drop side: float via start/valid unless synchronous
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            drop_bus_data <= 8'h00;
            drop_payload_valid <= 1'b0;
            drop_trib_start <= 1'b0;
            drop_bus_oe <= 1'b0;
        end else begin
            drop_bus_oe <= d_slot;
            drop_bus_data <= d_slot ? drop_src_data : 8'h00;
            drop_payload_valid <= d_slot && (drop_src_valid || sync_vtrib);
            drop_trib_start <= d_slot && drop_src_start && !sync_vtrib;
        end
    end

    // RQ2 RQ10 add side: payload octets taken when valid, or all of them when synchronous
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            add_sink_data <= 8'h00;
            add_sink_valid <= 1'b0;
            add_sink_start <= 1'b0;
            add_sink_spe <= 2'h0;
            add_sink_trib <= 5'h00;
        end else begin
            add_sink_data <= add_bus_data;
            add_sink_valid <= a_slot && (add_payload_valid || sync_vtrib);
            add_sink_start <= a_slot && add_trib_start && !sync_vtrib;
            add_sink_spe <= a_dec[8:7];
            add_sink_trib <= a_dec[6:2];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            drop_col <= 9'h001;
            drop_row <= 4'h1;
            config_error <= 1'b0;
        end else begin
            drop_col <= d_col_q;
            drop_row <= d_row_q;
            config_error <= cfg_bad;
        end
    end

    // RQ5 envelope type behind the current drop octet
    wire [2:0] d_ty = type_q[d_dec[8:7]];
    wire d_wide = (d_ty == 3'(trib_bus_pkg::TRIB_DS3)) || (d_ty == 3'(trib_bus_pkg::TRIB_E3));
    wire d_narrow = (d_ty == 3'(trib_bus_pkg::TRIB_T1)) || (d_ty == 3'(trib_bus_pkg::TRIB_VT15));
    localparam logic [4:0] T1_MAX = 5'(trib_bus_pkg::T1_PER_SPE);
    localparam logic [4:0] E1_MAX = 5'(trib_bus_pkg::E1_PER_SPE);

    // RQ3 pulse lands the counter on row 1 column 7
    fp_align_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ3
        drop_frame_pulse |=> (d_col_q == COL_FP && d_row_q == ROW_FP))
        else $error("drop counter not at frame octet after pulse");
    // RQ19 column stays in range
    col_range_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ19
        d_col_q >= 9'h001 && d_col_q <= COL_LAST)
        else $error("drop column out of range");
    // RQ14 idle columns never drive
    idle_cols_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ14
        (d_col_q <= COL_FIX && !d_wide) |=> !drop_bus_oe)
        else $error("drive in idle column");
    // RQ2 nothing before payload region
    pay_region_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ2
        (d_col_q < COL_PAY) |=> !drop_payload_valid)
        else $error("valid outside payload");
    // RQ1 only own lane driven
    lane_own_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ1
        (d_lane_q != OWN_LANE) |=> !drop_bus_oe)
        else $error("drive on foreign lane");
    // RQ11 synchronous mode drops start indicator
    sync_start_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ11
        sync_vtrib |=> !drop_trib_start)
        else $error("start flag in synchronous mode");
    // RQ4 add counter ignores drop pulse
    add_indep_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ4
        (drop_frame_pulse && !add_frame_pulse && a_lane_q == 2'h0)
        |=> a_lane_q == 2'h1)
        else $error("add counter disturbed by drop pulse");
    // RQ9 lanes advance every cycle
    lane_step_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ9
        !drop_frame_pulse |=> d_lane_q == $past(d_lane_q) + 2'h1)
        else $error("lane counter stalled");

    // RQ5 tributary index limits
    trib_limit_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ5
        d_slot |-> (d_dec[6:2] >= 5'h01
                    && d_dec[6:2] <= (d_wide ? 5'h01 : d_narrow ? T1_MAX : E1_MAX)))
        else $error("tributary index beyond envelope capacity");
    // RQ3 add pulse lands the add counter
    add_fp_align_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ3
        add_frame_pulse |=> (a_col_q == COL_FP && a_row_q == ROW_FP && a_lane_q == 2'h1))
        else $error("add counter not at frame octet after pulse");
    // RQ19 rows stay in range
    row_range_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ19
        d_row_q >= 4'h1 && d_row_q <= ROW_LAST && a_row_q >= 4'h1 && a_row_q <= ROW_LAST)
        else $error("row counter out of range");

    // RQ19 frame end wraps to the first octet
    sequence d_frame_end_s;
        d_col_wrap && d_row_q == ROW_LAST && !drop_frame_pulse;
    endsequence
    sequence d_frame_start_s;
        d_lane_q == 2'h0 && d_col_q == 9'h001 && d_row_q == 4'h1;
    endsequence
    frame_wrap_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ19
        d_frame_end_s |=> d_frame_start_s)
        else $error("frame did not wrap to row 1 column 1");
    // RQ19 column advances after each lane group
    sequence d_group_end_s;
        d_lane_wrap && !d_col_wrap && !drop_frame_pulse;
    endsequence
    col_step_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ19
        d_group_end_s |=> d_col_q == $past(d_col_q) + 9'h001)
        else $error("column did not advance");

    // RQ2 add side takes nothing before payload
    add_region_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ2
        (a_col_q < COL_PAY) |=> !add_sink_valid)
        else $error("add octet taken outside payload");
    // RQ1 add side listens on its own lane only
    add_lane_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ1
        (a_lane_q != OWN_LANE) |=> !add_sink_valid)
        else $error("add octet taken on foreign lane");

    // RQ10 slot data and start pass through
    drop_pass_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ10
        d_slot |=> (drop_bus_oe && drop_bus_data == $past(drop_src_data)
                    && drop_trib_start == ($past(drop_src_start) && !$past(sync_vtrib))))
        else $error("drop slot octet not passed through");
    // RQ11 synchronous mode forces payload valid
    sync_valid_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ11
        (d_slot && sync_vtrib) |=> drop_payload_valid)
        else $error("payload valid low in synchronous mode");
    // RQ12 wide envelope fills its columns
    wide_fill_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ12
        (d_lane_q == OWN_LANE && d_wide && d_col_q >= COL_PAY) |=> drop_bus_oe)
        else $error("wide envelope column left idle");
    // RQ7 bad type code raises the flag
    cfg_flag_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ7
        cfg_bad |=> config_error)
        else $error("configuration error not flagged");
    // RQ16 second E1 group restarts at one
    e1_pair_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ16
        (d_col_q == 9'h053 && d_ty == 3'(trib_bus_pkg::TRIB_E1)) |-> d_dec[6:2] == 5'h01)
        else $error("E1 column pairing broken");
    // RQ15 third T1 group restarts at one
    t1_pair_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ15
        (d_col_q == 9'h0bb && d_ty == 3'(trib_bus_pkg::TRIB_T1)) |-> d_dec[8:2] == 7'h01)
        else $error("T1 column pairing broken");
    // RQ18 slow source leaves its octet unused
    retard_gap_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ18
        (d_slot && !drop_src_valid && !sync_vtrib) |=> !drop_payload_valid)
        else $error("unused octet marked valid");
    // RQ13 wide envelopes carry index one
    wide_index_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ13
        (d_slot && d_wide) |-> d_dec[6:2] == 5'h01)
        else $error("wide envelope index not one");
    // RQ9 add lanes advance every cycle
    add_step_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ9
        !add_frame_pulse |=> a_lane_q == $past(a_lane_q) + 2'h1)
        else $error("add lane counter stalled");
endmodule : tributary_bus_frame_mapper

// [verification/link_device_model.sv]
module link_device_model (
    input wire logic core_clk,
    input wire logic rstn,
    output logic add_frame_pulse,
    output logic [7:0] add_bus_data,
    output logic add_payload_valid,
    output logic add_trib_start,
    output logic [8:0] slot_col,
    output logic [1:0] slot_lane
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] row_q;
    logic [7:0] seed_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            slot_lane <= 2'h0;
            slot_col <= 9'h005;
            row_q <= 4'h1;
            seed_q <= 8'h3c;
        end else begin
            seed_q <= seed_q * 8'h05 + 8'h01;
            slot_lane <= slot_lane + 2'h1;
            if (slot_lane == 2'h3) begin
                slot_col <= (slot_col == 9'h10e) ? 9'h001 : slot_col + 9'h001;
                if (slot_col == 9'h10e) begin
                    row_q <= (row_q == 4'h9) ? 4'h1 : row_q + 4'h1;
                end
            end
        end
    end
    assign add_frame_pulse = slot_lane == 2'h0 && slot_col == 9'h007 && row_q == 4'h1;
    assign add_payload_valid = slot_col >= 9'h013;
    assign add_trib_start = add_payload_valid && row_q == 4'h1 && slot_col < 9'h016;
    // idle octets inverted so stale data never matches
    assign add_bus_data = add_payload_valid ? seed_q : ~seed_q;
endmodule : link_device_model

// [verification/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rstn, drop_frame_pulse, sync_vtrib, drop_src_valid, drop_src_start;
    logic [2:0] spe1_type, spe2_type, spe3_type;
    logic [7:0] drop_src_data, drop_bus_data, add_bus_data, add_sink_data;
    logic add_frame_pulse, add_payload_valid, add_trib_start, drop_payload_valid;
    logic drop_trib_start, drop_bus_oe, add_sink_valid, add_sink_start, config_error;
    logic [1:0] add_sink_spe, slot_lane, lane;
    logic [4:0] add_sink_trib;
    logic [8:0] drop_col, slot_col, col;
    logic [3:0] drop_row, row;
    logic [31:0] seed;
    logic [22:0] drop_q[$];
    logic [22:0] drop_exp;
    logic [15:0] add_q[$];
    int miscompares, check_count;
    bit live, pulse_d, ds3_on;

    tributary_bus_frame_mapper #(.DEV_LANE(0)) tributary_bus_frame_mapper_inst (
        .core_clk, .rstn, .add_frame_pulse, .drop_frame_pulse, .spe1_type, .spe2_type,
        .spe3_type, .sync_vtrib, .drop_src_data, .drop_src_valid, .drop_src_start,
        .add_bus_data, .add_payload_valid, .add_trib_start, .drop_bus_data,
        .drop_payload_valid, .drop_trib_start, .drop_bus_oe, .add_sink_data,
        .add_sink_valid, .add_sink_start, .add_sink_spe, .add_sink_trib, .drop_col,
        .drop_row, .config_error);
    link_device_model link_device_model_inst (.core_clk, .rstn, .add_frame_pulse,
        .add_bus_data, .add_payload_valid, .add_trib_start, .slot_col, .slot_lane);

    task automatic compare_word(input logic [21:0] got, input logic [21:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : compare_word

    task automatic compare_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : compare_flag

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // envelope 2 carries e1, the others t1; envelope 1 may turn to ds3 late on
    function automatic logic [15:0] add_note(input logic [8:0] c, input logic [7:0] d,
                                             input logic st, input bit ds3);
        int k;
        int t;
        k = int'(c) - 16;
        t = (k % 3 == 1) ? (k - 3) % 63 / 3 + 1 : (k - 3) % 84 / 3 + 1;
        if (ds3 && k % 3 == 0) t = 1;
        return {2'(k % 3), 5'(t), st, d};
    endfunction : add_note

    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        #1_000_000;
        miscompares++;
        wrap_up();
    end

    initial forever begin
        @(posedge core_clk);
        #2;
        if (live && drop_bus_oe !== 1'b0) begin
            if (drop_q.size() == 0) begin
                compare_flag(drop_bus_oe, 1'b0);
            end else begin
                drop_exp = drop_q.pop_front();
                compare_word({drop_col, drop_row, drop_trib_start, drop_bus_data},
                             drop_exp[21:0]);
                compare_flag(drop_payload_valid, drop_exp[22]);
            end
        end
        if (live && add_sink_valid !== 1'b0) begin
            compare_word({6'h00, add_sink_spe, add_sink_trib, add_sink_start, add_sink_data},
                         {6'h00, add_q.size() ? add_q.pop_front() : 16'hffff});
        end
    end

    initial begin
        rstn = 0;
        drop_frame_pulse = 0;
        sync_vtrib = 0;
        drop_src_valid = 1;
        drop_src_start = 0;
        drop_src_data = 8'h00;
        spe1_type = trib_bus_pkg::TRIB_T1;
        spe2_type = trib_bus_pkg::TRIB_E1;
        spe3_type = trib_bus_pkg::TRIB_T1;
        seed = 32'h0000_700c;
        lane = 2'h0;
        col = 9'h001;
        row = 4'h1;
        repeat (4) @(posedge core_clk);
        compare_word({drop_col, drop_row, 9'h000}, {9'h001, 4'h1, 9'h000});
        #1 rstn = 1;
        for (int n = 0; n < 21000; n++) begin
            @(posedge core_clk);
            #1;
            live |= pulse_d;
            lane = pulse_d ? 2'h1 : lane + 2'h1;
            if (pulse_d) begin
                col = 9'h007;
                row = 4'h1;
            end else if (lane == 2'h0) begin
                col = (col == 9'h10e) ? 9'h001 : col + 9'h001;
                if (col == 9'h001) row = (row == 4'h9) ? 4'h1 : row + 4'h1;
            end
            seed = lfsr_next(seed);
            drop_src_data = seed[7:0];
            drop_src_start = seed[8];
            drop_src_valid = seed[9];
            // switch only where neither side has a slot this cycle
            if (!ds3_on && n > 15000 && lane != 2'h0 && slot_lane != 2'h0) begin
                ds3_on = 1;
                sync_vtrib = 1;
                spe1_type = trib_bus_pkg::TRIB_DS3;
            end
            pulse_d = n == 0 || n == 12345 || (live && lane == 0 && col == 7 && row == 1);
            drop_frame_pulse = pulse_d;
            if (live && lane == 2'h0 && (col >= 9'h013 || (ds3_on && col == 9'h010))) begin
                drop_q.push_back({seed[9] | sync_vtrib, col, row, seed[8] & !sync_vtrib,
                                  seed[7:0]});
            end
            if (slot_lane == 2'h0 && (add_payload_valid || (sync_vtrib && ds3_on
                                                             && slot_col == 9'h010))) begin
                add_q.push_back(add_note(slot_col, add_bus_data,
                                         add_trib_start && !sync_vtrib, ds3_on));
            end
        end
        @(posedge core_clk);
        #3;
        live = 0;
        compare_word(22'(drop_q.size() + add_q.size()), 22'h0);
        compare_flag(config_error, 1'b0);
        @(posedge core_clk);
        #1;
        spe3_type = 3'h7;
        repeat (2) @(posedge core_clk);
        #1;
        compare_flag(config_error, 1'b1);
        wrap_up();
    end
endmodule : tb
